// ### src/l1dc_cache.sv
/*
 * Level-one data cache: two-way, read-allocate, write-back, with a
 * serialising slave DMA path to level-two RAM and range flush.
 * Assumes one clock, requests held until acknowledged, and a
 * level-two port that answers each word access with one ack.
 */
`timescale 1ns/10ps
module l1dc_cache (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_cfg_l1_ram,
    input wire logic i_cfg_l2_all_cache,
    input wire logic i_cpu_req,
    input wire logic i_cpu_we,
    input wire l1dc_pkg::l1dc_addr_t i_cpu_addr,
    input wire l1dc_pkg::l1dc_data_t i_cpu_wdata,
    output logic o_cpu_ack,
    output l1dc_pkg::l1dc_data_t o_cpu_rdata,
    input wire logic i_slv_req,
    input wire logic i_slv_we,
    input wire l1dc_pkg::l1dc_addr_t i_slv_addr,
    input wire l1dc_pkg::l1dc_data_t i_slv_wdata,
    output logic o_slv_ack,
    output logic o_slv_err,
    output l1dc_pkg::l1dc_data_t o_slv_rdata,
    input wire logic i_wbinv_req,
    input wire l1dc_pkg::l1dc_addr_t i_wbinv_lo,
    input wire l1dc_pkg::l1dc_addr_t i_wbinv_hi,
    output logic o_wbinv_done,
    output logic o_l2_req,
    output logic o_l2_we,
    output l1dc_pkg::l1dc_addr_t o_l2_addr,
    output l1dc_pkg::l1dc_data_t o_l2_wdata,
    input wire logic i_l2_ack,
    input wire l1dc_pkg::l1dc_data_t i_l2_rdata
);
    import l1dc_pkg::*;

    function automatic logic [SET_W-1:0] f_set(input l1dc_addr_t a);
        f_set = a[SET_LSB +: SET_W];
    endfunction

    function automatic logic [TAG_W-1:0] f_tag(input l1dc_addr_t a);
        f_tag = a[TAG_LSB +: TAG_W];
    endfunction

    function automatic logic [WORD_W-1:0] f_word(input l1dc_addr_t a);
        f_word = a[WORD_LSB +: WORD_W];
    endfunction

    // Storage, no reset: contents are qualified by valid bits
    l1dc_data_t data_mem [2**IDX_W];
    logic [TAG_W-1:0] tag_mem [2**SLOT_W];

    l1dc_state_t state_reg;
    logic [WORD_W-1:0] beat_reg;
    logic way_reg;
    logic [SET_W-1:0] set_reg;
    l1dc_addr_t addr_reg;
    logic we_reg;
    logic is_slv_reg;
    logic flush_reg;
    logic [SLOT_W-1:0] scan_reg;
    logic [2**SLOT_W-1:0] valid_reg;
    logic [2**SLOT_W-1:0] dirty_reg;
    logic [SETS-1:0] lru_reg;
    l1dc_data_t wdata_reg;
    logic cpu_ack_reg;
    logic slv_ack_reg;
    logic slv_err_reg;
    logic done_reg;
    l1dc_data_t cpu_rdata_reg;
    l1dc_data_t slv_rdata_reg;

    // Previous answer still showing blocks the held request
    wire idle_go = (state_reg == ST_IDLE) && !cpu_ack_reg &&
        !slv_ack_reg && !done_reg;
    // Slave first: its latency matters more than the CPU's
    wire slv_go = idle_go && i_slv_req;
    wire flush_go = idle_go && !i_slv_req && i_wbinv_req;
    wire cpu_go = idle_go && !i_slv_req && !i_wbinv_req && i_cpu_req;
    wire ram_go = cpu_go && i_cfg_l1_ram;
    wire l1dc_addr_t req_addr = i_slv_req ? i_slv_addr : i_cpu_addr;
    wire [SET_W-1:0] req_set = f_set(req_addr);
    wire slot0_valid = valid_reg[{1'b0, req_set}];
    wire slot1_valid = valid_reg[{1'b1, req_set}];
    wire hit0 = slot0_valid && tag_mem[{1'b0, req_set}] == f_tag(req_addr);
    wire hit1 = slot1_valid && tag_mem[{1'b1, req_set}] == f_tag(req_addr);
    wire hit_any = !i_cfg_l1_ram && (hit0 || hit1);
    wire hit_way = hit1;
    wire victim_way = !slot0_valid ? 1'b0 :
        (!slot1_valid ? 1'b1 : lru_reg[req_set]);
    wire [SLOT_W-1:0] hit_slot = {hit_way, req_set};
    wire [SLOT_W-1:0] vic_slot = {victim_way, req_set};
    wire [SLOT_W-1:0] cur_slot = {way_reg, set_reg};
    wire [IDX_W-1:0] hit_idx = {hit_slot, f_word(req_addr)};
    wire [IDX_W-1:0] ram_idx = i_cpu_addr[WORD_LSB +: IDX_W];
    wire [IDX_W-1:0] line_idx = {cur_slot, beat_reg};

    wire fill_beat = (state_reg == ST_FILL) && i_l2_ack;
    wire fill_last = fill_beat && beat_reg == LAST_BEAT;
    wire wb_last = (state_reg == ST_WB) && i_l2_ack &&
        beat_reg == LAST_BEAT;
    wire slv_ok = !i_cfg_l2_all_cache;
    wire dm_we = (cpu_go && i_cpu_we && (i_cfg_l1_ram || hit_any)) ||
        (slv_go && slv_ok && i_slv_we && hit_any) || fill_beat;
    wire [IDX_W-1:0] dm_idx = fill_beat ? line_idx :
        (ram_go ? ram_idx : hit_idx);
    wire l1dc_data_t dm_wd = fill_beat ? i_l2_rdata :
        (slv_go ? i_slv_wdata : i_cpu_wdata);

    wire [LINE_W-1:0] scan_line = {tag_mem[scan_reg], scan_reg[SET_W-1:0]};
    wire scan_hit = valid_reg[scan_reg] &&
        scan_line >= i_wbinv_lo[ADDR_W-1:SET_LSB] &&
        scan_line <= i_wbinv_hi[ADDR_W-1:SET_LSB];
    wire [1:0] zero2 = 2'b00;

    // Victims leave only toward level two, whole lines beat by beat
    assign o_l2_req = state_reg == ST_WB || state_reg == ST_FILL ||
        state_reg == ST_WORD;
    assign o_l2_we = state_reg == ST_WB ||
        (state_reg == ST_WORD && we_reg);
    assign o_l2_addr = state_reg == ST_WB ?
        {tag_mem[cur_slot], set_reg, beat_reg, zero2} :
        (state_reg == ST_FILL ?
        {addr_reg[ADDR_W-1:SET_LSB], beat_reg, zero2} : addr_reg);
    assign o_l2_wdata = state_reg == ST_WB ? data_mem[line_idx] : wdata_reg;
    assign o_cpu_ack = cpu_ack_reg;
    assign o_cpu_rdata = cpu_rdata_reg;
    assign o_slv_ack = slv_ack_reg;
    assign o_slv_err = slv_err_reg;
    assign o_slv_rdata = slv_rdata_reg;
    assign o_wbinv_done = done_reg;

    always_ff @(posedge i_mclk) begin
        if (dm_we) begin
            data_mem[dm_idx] <= dm_wd;
        end
        if (fill_last) begin
            tag_mem[cur_slot] <= f_tag(addr_reg);
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= ST_IDLE;
            beat_reg <= BEAT_RST;
            way_reg <= 1'b0;
            set_reg <= '0;
            addr_reg <= '0;
            we_reg <= 1'b0;
            is_slv_reg <= 1'b0;
            flush_reg <= 1'b0;
            scan_reg <= SLOT_RST;
            valid_reg <= '0;
            dirty_reg <= '0;
            lru_reg <= '0;
            wdata_reg <= DATA_RST;
            cpu_ack_reg <= 1'b0;
            slv_ack_reg <= 1'b0;
            slv_err_reg <= 1'b0;
            done_reg <= 1'b0;
            cpu_rdata_reg <= DATA_RST;
            slv_rdata_reg <= DATA_RST;
        end else begin
            cpu_ack_reg <= 1'b0;
            slv_ack_reg <= 1'b0;
            slv_err_reg <= 1'b0;
            done_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    addr_reg <= req_addr;
                    beat_reg <= BEAT_RST;
                    if (slv_go) begin
                        // Whole slave access runs alone, never mid-victim
                        is_slv_reg <= 1'b1;
                        we_reg <= i_slv_we;
                        wdata_reg <= i_slv_wdata;
                        if (!slv_ok) begin
                            slv_ack_reg <= 1'b1;
                            slv_err_reg <= 1'b1;
                        end else if (hit_any && !i_slv_we) begin
                            // Cached copy may be newer than level two
                            slv_rdata_reg <= data_mem[hit_idx];
                            slv_ack_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_WORD;
                        end
                    end else if (flush_go) begin
                        scan_reg <= SLOT_RST;
                        state_reg <= ST_SCAN;
                    end else if (ram_go) begin
                        cpu_rdata_reg <= data_mem[ram_idx];
                        cpu_ack_reg <= 1'b1;
                    end else if (cpu_go && hit_any) begin
                        cpu_rdata_reg <= data_mem[hit_idx];
                        cpu_ack_reg <= 1'b1;
                        lru_reg[req_set] <= ~hit_way;
                        if (i_cpu_we) begin
                            dirty_reg[hit_slot] <= 1'b1;
                        end
                    end else if (cpu_go && i_cpu_we) begin
                        is_slv_reg <= 1'b0;
                        we_reg <= 1'b1;
                        wdata_reg <= i_cpu_wdata;
                        state_reg <= ST_WORD;
                    end else if (cpu_go) begin
                        is_slv_reg <= 1'b0;
                        way_reg <= victim_way;
                        set_reg <= req_set;
                        if (valid_reg[vic_slot] && dirty_reg[vic_slot]) begin
                            state_reg <= ST_WB;
                        end else begin
                            state_reg <= ST_FILL;
                        end
                    end
                end
                ST_WB: begin
                    if (i_l2_ack) begin
                        beat_reg <= beat_reg + 4'h1;
                    end
                    if (wb_last) begin
                        valid_reg[cur_slot] <= 1'b0;
                        dirty_reg[cur_slot] <= 1'b0;
                        flush_reg <= 1'b0;
                        state_reg <= flush_reg ? ST_SCAN : ST_FILL;
                    end
                end
                ST_FILL: begin
                    if (fill_beat) begin
                        beat_reg <= beat_reg + 4'h1;
                        if (beat_reg == f_word(addr_reg)) begin
                            cpu_rdata_reg <= i_l2_rdata;
                        end
                    end
                    if (fill_last) begin
                        valid_reg[cur_slot] <= 1'b1;
                        dirty_reg[cur_slot] <= 1'b0;
                        lru_reg[set_reg] <= ~way_reg;
                        cpu_ack_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_WORD: begin
                    if (i_l2_ack) begin
                        slv_rdata_reg <= i_l2_rdata;
                        slv_ack_reg <= is_slv_reg;
                        cpu_ack_reg <= !is_slv_reg;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_SCAN: begin
                    if (scan_hit && dirty_reg[scan_reg]) begin
                        // Dirty line in range: write back, then rescan it
                        way_reg <= scan_reg[SLOT_W-1];
                        set_reg <= scan_reg[SET_W-1:0];
                        beat_reg <= BEAT_RST;
                        flush_reg <= 1'b1;
                        state_reg <= ST_WB;
                    end else begin
                        if (scan_hit) begin
                            valid_reg[scan_reg] <= 1'b0;
                        end
                        if (scan_reg == LAST_SLOT) begin
                            done_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                        end else begin
                            scan_reg <= scan_reg + 5'h01;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// ### common/l1dc_pkg.sv
/*
 * Constants and types for the level-one data cache block.
 * Assumes 32-bit byte addresses and 32-bit words on every port.
 */
// Notes on behaviour
// - Two-way set associative, two slots per address
// - Lines are 64 bytes, moved whole
// - Only CPU read misses allocate lines
// - CPU write hit marks line dirty, no write-through
// - Write back only on eviction or request
// - Read miss over dirty line evicts it first
// - Level-two may be configured all cache
// - Level-one data may run as plain RAM
// - Victims go to level-two controller only
package l1dc_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int LINE_BYTES = 64;
    localparam int WAYS = 2;
    localparam int SETS = 16;
    localparam int WORDS = LINE_BYTES / 4;
    localparam int WORD_LSB = 2;
    localparam int WORD_W = 4;
    localparam int SET_LSB = 6;
    localparam int SET_W = 4;
    localparam int TAG_LSB = 10;
    localparam int TAG_W = ADDR_W - TAG_LSB;
    localparam int SLOT_W = SET_W + 1;
    localparam int IDX_W = SLOT_W + WORD_W;
    localparam int LINE_W = ADDR_W - SET_LSB;
    localparam logic [WORD_W-1:0] LAST_BEAT = 4'hf;
    localparam logic [SLOT_W-1:0] LAST_SLOT = 5'h1f;
    localparam logic [WORD_W-1:0] BEAT_RST = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_RST = 5'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

    typedef logic [ADDR_W-1:0] l1dc_addr_t;
    typedef logic [DATA_W-1:0] l1dc_data_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_WB, ST_FILL, ST_WORD, ST_SCAN
    } l1dc_state_t;
endpackage

// ### verif/l1dc_cache_checker.sv
/* Port assertions for the level-one data cache.
   One clock, asynchronous active-low reset; bound after the module. */
`timescale 1ns/10ps
module l1dc_cache_checker (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_cfg_l1_ram,
    input wire logic i_cfg_l2_all_cache,
    input wire logic i_cpu_req,
    input wire logic i_slv_req,
    input wire logic i_wbinv_req,
    input wire logic o_cpu_ack,
    input wire logic o_slv_ack,
    input wire logic o_slv_err,
    input wire logic o_wbinv_done,
    input wire logic o_l2_req,
    input wire logic o_l2_we,
    input wire l1dc_pkg::l1dc_addr_t o_l2_addr,
    input wire l1dc_pkg::l1dc_data_t o_l2_wdata,
    input wire logic i_l2_ack
);
    import l1dc_pkg::*;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    a_l2_hold: assert property (o_l2_req && !i_l2_ack |=> o_l2_req
        && $stable(o_l2_addr) && $stable(o_l2_we) && $stable(o_l2_wdata))
        else $error("l2 request moved before ack");
    a_cpu_ack_src: assert property (o_cpu_ack |-> !$past(o_l2_req)
        || $past(i_l2_ack)) else $error("cpu ack off l2 end");
    a_ram_local: assert property ($past(i_cfg_l1_ram) && o_cpu_ack
        |-> !$past(o_l2_req) && !$past(o_l2_req, 2))
        else $error("ram mode used l2");
    a_idle_quiet: assert property (!o_l2_req && !i_cpu_req &&
        !i_slv_req && !i_wbinv_req |=> !o_l2_req)
        else $error("l2 traffic without request");
    a_err_mode: assert property (o_slv_ack || o_slv_err |->
        o_slv_ack && o_slv_err == $past(i_cfg_l2_all_cache))
        else $error("slave error wrong");
    a_one_answer: assert property (!(o_cpu_ack && o_slv_ack) &&
        !(o_wbinv_done && (o_cpu_ack || o_slv_ack)))
        else $error("two answers at once");
    a_done_drained: assert property (o_wbinv_done |->
        !o_l2_req && !$past(o_l2_req)) else $error("done with l2 busy");
    a_wb_first: assert property (o_l2_req && !o_l2_we && i_l2_ack
        |=> !(o_l2_req && o_l2_we)) else $error("write after fill");
    cover property (o_cpu_ack && $past(i_l2_ack));
    cover property (o_slv_err);
    cover property (o_wbinv_done && $past(o_l2_req, 2));
endmodule
bind l1dc_cache l1dc_cache_checker l1dc_cache_checker_i (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cfg_l1_ram(i_cfg_l1_ram),
    .i_cfg_l2_all_cache(i_cfg_l2_all_cache), .i_cpu_req(i_cpu_req),
    .i_slv_req(i_slv_req), .i_wbinv_req(i_wbinv_req),
    .o_cpu_ack(o_cpu_ack), .o_slv_ack(o_slv_ack), .o_slv_err(o_slv_err),
    .o_wbinv_done(o_wbinv_done), .o_l2_req(o_l2_req), .o_l2_we(o_l2_we),
    .o_l2_addr(o_l2_addr), .o_l2_wdata(o_l2_wdata), .i_l2_ack(i_l2_ack));

// ### verif/l1dc_l2_model.sv
/* Level-two memory model behind the cache's word port.
   Requests held until ack; slow adds wait cycles. */
`timescale 1ns/10ps
module l1dc_l2_model (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_slow,
    input wire logic i_req,
    input wire logic i_we,
    input wire l1dc_pkg::l1dc_addr_t i_addr,
    input wire l1dc_pkg::l1dc_data_t i_wdata,
    output logic o_ack,
    output l1dc_pkg::l1dc_data_t o_rdata
);
    import l1dc_pkg::*;
    l1dc_data_t mem [0:1023];
    l1dc_data_t rd_reg;
    logic [1:0] wait_reg;
    logic go;
    // Stale data inverted so a late sample cannot pass by luck
    assign o_rdata = o_ack ? rd_reg : ~rd_reg;
    assign go = i_req && !o_ack && (wait_reg == 2'h3 || !i_slow);
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] <= 32'h5a000000 + 32'(i);
        end
    end
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ack <= 1'b0;
            wait_reg <= 2'h0;
            rd_reg <= 32'h0;
        end else begin
            o_ack <= go;
            wait_reg <= (i_req && !go && !o_ack) ? wait_reg + 2'h1 : 2'h0;
            if (go && i_we) mem[i_addr[11:2]] <= i_wdata;
            if (go && !i_we) rd_reg <= mem[i_addr[11:2]];
        end
    end
endmodule

// ### verif/l1dc_cache_tb.sv
/* Bench for the level-one data cache against a level-two model.
   Drives on falling edges; expectations come from a shadow memory. */
`timescale 1ns/10ps
module l1dc_cache_tb;
    import l1dc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ram = 1'b0, allc = 1'b0, slow = 1'b0;
    logic we = 1'b0, err, serr, l2req, l2we, l2ack;
    logic [2:0] req = 3'h0;
    wire logic [2:0] ack;
    l1dc_addr_t ad = 32'h0, hi = 32'h0, l2a;
    l1dc_data_t wd = 32'h0, crd, srd, l2wd, l2rd;
    l1dc_data_t sh [0:1023];
    logic [31:0] seed = 32'h3fb4604a;
    int miscompares = 0, n_tests = 0, cyc = 0;
    l1dc_cache l1dc_cache_i (.i_mclk(clk), .i_arst_n(rst_n),
        .i_cfg_l1_ram(ram), .i_cfg_l2_all_cache(allc), .i_cpu_req(req[0]),
        .i_cpu_we(we), .i_cpu_addr(ad), .i_cpu_wdata(wd), .o_cpu_ack(ack[0]),
        .o_cpu_rdata(crd), .i_slv_req(req[1]), .i_slv_we(we),
        .i_slv_addr(ad), .i_slv_wdata(wd), .o_slv_ack(ack[1]),
        .o_slv_err(serr), .o_slv_rdata(srd), .i_wbinv_req(req[2]),
        .i_wbinv_lo(ad), .i_wbinv_hi(hi), .o_wbinv_done(ack[2]),
        .o_l2_req(l2req), .o_l2_we(l2we), .o_l2_addr(l2a),
        .o_l2_wdata(l2wd), .i_l2_ack(l2ack), .i_l2_rdata(l2rd));
    l1dc_l2_model l1dc_l2_model_i (.i_mclk(clk), .i_arst_n(rst_n),
        .i_slow(slow), .i_req(l2req), .i_we(l2we), .i_addr(l2a),
        .i_wdata(l2wd), .o_ack(l2ack), .o_rdata(l2rd));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic l1dc_data_t mw(input int i);
        return l1dc_l2_model_i.mem[i];
    endfunction
    task automatic complete_run();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input l1dc_data_t got, input l1dc_data_t exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One request on cpu (0), slave (1) or flush (2); held until answered
    task automatic xfer(input int k, input logic w, input l1dc_addr_t a,
        input l1dc_data_t d, output l1dc_data_t r);
        @(negedge clk);
        we = w;
        ad = a;
        wd = d;
        hi = d;
        slow = 1'(xs());
        req[k] = 1'b1;
        do begin
            @(posedge clk);
            #1;
        end while (ack[k] !== 1'b1);
        r = k == 1 ? srd : crd;
        err = serr;
        @(negedge clk);
        req = 3'h0;
    endtask
    task automatic op(input int k, input logic w, input l1dc_addr_t a,
        input l1dc_data_t d);
        l1dc_data_t r;
        xfer(k, w, a, d, r);
        if (w) sh[a[11:2]] = d;
        else chk(r, sh[a[11:2]]);
    endtask
    task automatic flush_all();
        l1dc_data_t r;
        xfer(2, 1'b0, 32'h0, 32'hfff, r);
        for (int i = 0; i < 1024; i++) chk(mw(i), sh[i]);
    endtask
    initial forever #25 clk = ~clk;
    // Whole run needs well under this many cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        l1dc_addr_t a;
        l1dc_data_t r, d;
        for (int i = 0; i < 1024; i++) sh[i] = 32'h5a000000 + 32'(i);
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        // Four tags per set in 4 KB, so victims are frequent
        for (int i = 0; i < 200; i++) begin
            a = xs() & 32'hffc;
            op(xs() % 4 == 0, 1'(xs()), a, xs());
        end
        flush_all();
        $display("test random done");
        r = sh[16];
        op(0, 1'b0, 32'h040, 32'h0);
        op(0, 1'b1, 32'h040, 32'h1);
        chk(mw(16), r);
        op(0, 1'b0, 32'h440, 32'h0);
        op(0, 1'b0, 32'h840, 32'h0);
        chk(mw(16), 32'h1);
        op(0, 1'b1, 32'hc80, 32'h2);
        chk(mw(800), 32'h2);
        $display("test victim done");
        op(0, 1'b0, 32'h0c0, 32'h0);
        op(0, 1'b1, 32'h0c0, 32'h3);
        op(1, 1'b1, 32'h0cc, 32'h4);
        op(1, 1'b0, 32'h0c0, 32'h0);
        op(0, 1'b0, 32'h0cc, 32'h0);
        op(0, 1'b0, 32'h4c0, 32'h0);
        op(0, 1'b0, 32'h8c0, 32'h0);
        chk(mw(48), 32'h3);
        chk(mw(51), 32'h4);
        $display("test coherence done");
        op(0, 1'b0, 32'h100, 32'h0);
        op(0, 1'b0, 32'h140, 32'h0);
        r = sh[80];
        op(0, 1'b1, 32'h100, 32'h5);
        op(0, 1'b1, 32'h140, 32'h6);
        xfer(2, 1'b0, 32'h100, 32'h13f, d);
        chk(mw(64), 32'h5);
        chk(mw(80), r);
        flush_all();
        $display("test range flush done");
        allc = 1'b1;
        for (int w = 0; w < 2; w++) begin
            xfer(1, 1'(w), 32'h200, 32'h7, r);
            chk({31'h0, err}, 32'h1);
            chk(mw(128), sh[128]);
        end
        allc = 1'b0;
        ram = 1'b1;
        for (int i = 0; i < 8; i++) begin
            a = xs() & 32'h7fc;
            d = xs();
            xfer(0, 1'b1, a, d, r);
            xfer(0, 1'b0, a, 32'h0, r);
            chk(r, d);
            chk(mw(a[11:2]), sh[a[11:2]]);
        end
        $display("test modes done");
        complete_run();
    end
endmodule
